/* src/flag_fifo_top.sv */
// flag, read side and mark/retransmit logic of a mode-selectable fifo with serial offset load
// Overview of operation
// RULE1: standard mode: empty releases one cycle after write
// RULE2: first word readable after one flag cycle
// RULE3: fall-through: output ready low two cycles later
// RULE4: fall-through: input ready low cycle after read
// RULE5: almost-full rises one cycle after read
// RULE6: almost-empty rises one cycle after write
// RULE7: reader holds strobe high one cycle after select
// RULE8: first word falls through; later reads need both
// RULE9: retransmit done: empty high, or ready low
// RULE10: reader keeps retransmit high during normal reads
// RULE11: write pointer stops at the marked location
// RULE12: controller keeps pointer gap before setting mark
// RULE13: almost-empty may move one cycle early on rewind
// RULE14: nine-to-nine offsets are 12 to 20 bits
// RULE15: other widths: offsets are 11 to 19 bits
// RULE16: fall-through depth is array plus one word
// RULE17: almost-full changes only on clock edges
// RULE18: pointers pass through a delay stage between sides
`timescale 1ns/100ps
`default_nettype none
`include "fifo_map.svh"
module flag_fifo_top #(
  parameter int ADDR_W       = `FIFO_ADDR_W_MIN,   // array holds 2**ADDR_W words
  parameter int DATA_W       = `FIFO_DATA_W,       // word width
  parameter int XING_STAGES  = `FIFO_XING_STAGES,  // pointer delay stages
  parameter int BUF_DEPTH    = `FIFO_BUF_DEPTH,    // staging buffer depth
  parameter bit NINE_TO_NINE = 1'b0                // both ports nine bits wide
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  fall_through_mode,
  input  wire logic                  flag_timing_select,
  input  wire logic                  write_n,
  input  wire logic [DATA_W-1:0]     write_data,
  output      logic                  write_accept,
  input  wire logic                  read_n,
  input  wire logic                  read_select_n,
  input  wire logic                  retransmit_n,
  input  wire logic                  mark_n,
  input  wire logic                  load_n,
  input  wire logic                  serial_en_n,
  input  wire logic                  serial_in,
  output      logic [DATA_W-1:0]     read_data,
  output      logic                  empty_flag_n,
  output      logic                  input_ready_n,
  output      logic                  almost_empty_n,
  output      logic                  almost_full_n,
  output var  fifo_pkg::ofs_target_t load_target
);
  import fifo_pkg::*;

  localparam int DEPTH    = 1 << ADDR_W;   // array words
  localparam int PW       = ADDR_W + 1;    // pointer width with wrap bit
  // offset length grows by one per depth doubling
  localparam int OFS_BITS = (NINE_TO_NINE ? `FIFO_OFS_BITS_NINE_MIN : `FIFO_OFS_BITS_MIN)
                            + ADDR_W - `FIFO_ADDR_W_MIN;
  localparam int CW       = OFS_BITS + 2;  // compare width, holds offset plus occupancy
  localparam int LCW      = $clog2(OFS_BITS + 1);

  // straps caught once after reset release
  logic                strap_done_r;     // straps are valid
  logic                fall_through_mode_r;           // fall-through mode held
  logic                sync_flags_r;     // almost flags use delayed pointers

  // array and pointers
  logic [DATA_W-1:0]   mem_r [DEPTH];    // main array in flops
  logic [PW-1:0]       wr_ptr_r;         // write side pointer
  logic [PW-1:0]       rd_ptr_r;         // read side pointer
  logic [PW-1:0]       wr_pipe_r [XING_STAGES];  // write pointer as the read side sees it
  logic [PW-1:0]       rd_pipe_r [XING_STAGES];  // read pointer as the write side sees it
  logic [PW-1:0]       wr_seen;          // last stage of write pointer delay
  logic [PW-1:0]       rd_seen;          // last stage of read pointer delay

  // mark and rewind
  logic [PW-1:0]       mark_ptr_r;       // location kept for retransmission
  logic                mark_valid_r;     // mark is held
  logic                mark_n_q_r;       // previous mark input, for the falling edge
  rd_state_t           rd_state_r;       // run or rewinding
  logic                rewind_req;       // retransmit taken this cycle

  // read side
  logic                out_valid_r;      // output register holds a word (fall-through)
  logic [DATA_W-1:0]   read_data_r;      // output register
  logic                empty_rd;         // array empty as the read side sees it
  logic                strobe_on;        // both read inputs active
  logic                rd_take_std;      // standard mode read
  logic                rd_load_ft;       // fall-through load of the output register
  logic                rd_drop_ft;       // fall-through read with nothing behind it
  logic                rd_pop;           // array word leaves

  // write side
  logic [PW-1:0]       wr_base;          // oldest protected location
  logic [PW-1:0]       occ_w;            // words the writer may not overrun
  logic                full_w;           // array full for the writer
  logic                wr_do;            // word moves from staging buffer into array

  // programmable flags
  logic [OFS_BITS-1:0] ae_ofs_r;         // almost-empty offset
  logic [OFS_BITS-1:0] af_ofs_r;         // almost-full offset
  logic [LCW-1:0]      load_cnt_r;       // bits shifted into the current offset
  ofs_target_t         load_target_r;    // offset being loaded
  logic [PW-1:0]       wr_for_ae;        // write pointer used by almost-empty
  logic [PW-1:0]       rd_for_af;        // read pointer used by almost-full
  logic [CW-1:0]       occ_ae;           // occupancy seen by almost-empty
  logic [CW-1:0]       occ_af;           // occupancy seen by almost-full

  // staging buffer on the write path
  fifo_stream_if #(.WIDTH(DATA_W)) wr_stream ();

  fifo_store #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_stage (
    .clk  (clk),
    .rstn (rstn),
    .port (wr_stream.buffer)
  );

  // writer offers words into the buffer; its ready is the writer's back-pressure
  assign wr_stream.in_valid  = ~write_n;
  assign wr_stream.in_data   = write_data;
  assign write_accept        = wr_stream.in_ready;
  // buffer drains only while the array has room, so a full array fills it
  assign wr_stream.out_ready = strap_done_r & ~full_w;
  assign wr_do               = wr_stream.out_valid & wr_stream.out_ready;

  // straps: caught on the first edge after release, never under the reset itself
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_done_r <= 1'b0;
      fall_through_mode_r       <= 1'b0;
      sync_flags_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      fall_through_mode_r       <= fall_through_mode;
      sync_flags_r <= flag_timing_select;
    end
  end

  // pointer delay line; each stage adds one cycle of flag latency
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int s = 0; s < XING_STAGES; s++) begin
        wr_pipe_r[s] <= '0;
        rd_pipe_r[s] <= '0;
      end
    end else begin
      wr_pipe_r[0] <= wr_ptr_r;  // see RULE18
      rd_pipe_r[0] <= rd_ptr_r;  // see RULE18
      for (int s = 1; s < XING_STAGES; s++) begin
        wr_pipe_r[s] <= wr_pipe_r[s-1];
        rd_pipe_r[s] <= rd_pipe_r[s-1];
      end
    end
  end

  assign wr_seen = wr_pipe_r[XING_STAGES-1];
  assign rd_seen = rd_pipe_r[XING_STAGES-1];

  // write side occupancy counts from the mark while one is held,
  // so the writer can never climb over data kept for retransmission
  assign wr_base = mark_valid_r ? mark_ptr_r : rd_seen;  // see RULE11
  assign occ_w   = wr_ptr_r - wr_base;
  // array alone decides full; in fall-through the output register adds one word
  assign full_w  = (occ_w == PW'(DEPTH));  // see RULE16

  // array write, no reset on storage
  always_ff @(posedge clk) begin
    if (wr_do) begin
      mem_r[wr_ptr_r[ADDR_W-1:0]] <= wr_stream.out_data;
    end
  end

  // write pointer; held by full_w at the mark
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
    end else if (wr_do) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;  // see RULE11
    end
  end

  // read side decode; the rewind cycle reads as empty
  assign empty_rd    = (wr_seen == rd_ptr_r) | (rd_state_r == RD_REWIND);
  assign strobe_on   = ~read_n & ~read_select_n;
  assign rewind_req  = strap_done_r & ~retransmit_n & mark_valid_r & (rd_state_r == RD_RUN);
  // standard mode: a read needs both strobes, a word, and no retransmit
  assign rd_take_std = strap_done_r & ~fall_through_mode_r & strobe_on & retransmit_n & ~empty_rd;  // see RULE2
  // fall-through: the first word loads with no strobe, later ones need both
  assign rd_load_ft  = strap_done_r & fall_through_mode_r & retransmit_n & ~empty_rd
                       & (~out_valid_r | strobe_on);  // see RULE8
  assign rd_drop_ft  = fall_through_mode_r & out_valid_r & strobe_on & retransmit_n & empty_rd;
  assign rd_pop      = rd_take_std | rd_load_ft;

  // output register; a strobe that comes with select too early only
  // loses a word in the reader's logic, the register itself stays correct
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_data_r <= '0;
    end else if (rd_pop) begin
      read_data_r <= mem_r[rd_ptr_r[ADDR_W-1:0]];  // see RULE7
    end
  end

  // output register occupancy in fall-through mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_valid_r <= 1'b0;
    end else if (rewind_req) begin
      out_valid_r <= 1'b0;  // refilled from the mark after the rewind
    end else if (rd_load_ft) begin
      out_valid_r <= 1'b1;  // see RULE3
    end else if (rd_drop_ft) begin
      out_valid_r <= 1'b0;
    end
  end

  // read pointer: a retransmit request wins over a read in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr_r <= '0;
    end else if (rewind_req) begin
      rd_ptr_r <= mark_ptr_r;  // see RULE10
    end else if (rd_pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // rewind sequencing: one cycle of forced empty, then release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_state_r <= RD_RUN;
    end else begin
      unique case (rd_state_r)
        RD_RUN: begin
          if (rewind_req) begin
            rd_state_r <= RD_REWIND;
          end
        end
        RD_REWIND: begin
          rd_state_r <= RD_RUN;  // see RULE9
        end
      endcase
    end
  end

  // mark: position caught on the falling edge of mark_n, held while it stays low;
  // in fall-through the word already in the output register belongs to the mark
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mark_n_q_r   <= 1'b1;
      mark_valid_r <= 1'b0;
      mark_ptr_r   <= '0;
    end else begin
      mark_n_q_r   <= mark_n;
      mark_valid_r <= strap_done_r & ~mark_n;  // see RULE12
      if (strap_done_r && !mark_n && mark_n_q_r) begin
        mark_ptr_r <= rd_ptr_r - PW'(out_valid_r);
      end
    end
  end

  // serial offset load: almost-empty offset first, then almost-full,
  // lsb first, exactly OFS_BITS bits each
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ae_ofs_r      <= OFS_BITS'(`FIFO_AE_OFS_RST);
      af_ofs_r      <= OFS_BITS'(`FIFO_AF_OFS_RST);
      load_cnt_r    <= '0;
      load_target_r <= OFS_EMPTY_SIDE;
    end else if (!load_n && !serial_en_n) begin
      unique case (load_target_r)
        OFS_EMPTY_SIDE: begin
          ae_ofs_r <= {serial_in, ae_ofs_r[OFS_BITS-1:1]};
        end
        OFS_FULL_SIDE: begin
          af_ofs_r <= {serial_in, af_ofs_r[OFS_BITS-1:1]};
        end
      endcase
      if (load_cnt_r == LCW'(OFS_BITS - 1)) begin
        load_cnt_r    <= '0;  // see RULE14
        load_target_r <= (load_target_r == OFS_EMPTY_SIDE) ? OFS_FULL_SIDE : OFS_EMPTY_SIDE;  // see RULE15
      end else begin
        load_cnt_r <= load_cnt_r + 1'b1;
      end
    end
  end

  // almost-empty: writes clear it through the delay line in synchronous
  // timing, straight from the write pointer otherwise
  assign wr_for_ae = sync_flags_r ? wr_seen : wr_ptr_r;  // see RULE6
  // a rewind jumps rd_ptr_r at once, so the flag may move a cycle early
  assign occ_ae    = CW'(PW'(wr_for_ae - rd_ptr_r)) + CW'(fall_through_mode_r & out_valid_r);  // see RULE13

  // almost-full: reads clear it through the delay line in synchronous timing;
  // every input is a flop, so the flag moves only on rising clock edges
  assign rd_for_af = mark_valid_r ? mark_ptr_r : (sync_flags_r ? rd_seen : rd_ptr_r);  // see RULE17
  assign occ_af    = CW'(PW'(wr_ptr_r - rd_for_af));  // see RULE5

  // flag pins
  always_comb begin
    // shared pin: empty flag in standard mode, output ready in fall-through
    if (fall_through_mode_r) begin
      empty_flag_n  = ~out_valid_r;  // see RULE3
      input_ready_n = full_w;        // see RULE4
    end else begin
      empty_flag_n  = ~empty_rd;     // see RULE1
      input_ready_n = ~full_w;
    end
    almost_empty_n = ~(occ_ae <= CW'(ae_ofs_r));
    almost_full_n  = ~((occ_af + CW'(af_ofs_r)) >= CW'(DEPTH));
  end

  assign read_data   = read_data_r;
  assign load_target = load_target_r;

endmodule : flag_fifo_top
`default_nettype wire

/* common/fifo_map.svh */
// constant map of the flag fifo: sizes, offset bit counts, reset values and clock figures
`ifndef FIFO_MAP_SVH
`define FIFO_MAP_SVH

// array and word sizes (smallest organisation)
`define FIFO_ADDR_W_MIN        11
`define FIFO_DATA_W            18
`define FIFO_BUF_DEPTH         8

// pointer delay stages between the write view and the read view
`define FIFO_XING_STAGES       1

// serial offset lengths: nine-to-nine ports and every other combination
`define FIFO_OFS_BITS_NINE_MIN 12
`define FIFO_OFS_BITS_NINE_MAX 20
`define FIFO_OFS_BITS_MIN      11
`define FIFO_OFS_BITS_MAX      19

// offsets held after reset until the serial loader replaces them
`define FIFO_AE_OFS_RST        20'h0007F
`define FIFO_AF_OFS_RST        20'h0007F

// clock figure and the flag latency it gives
`define FIFO_CLK_PERIOD_NS     8
`define FIFO_FLAG_LAT_CYC      1

`endif

/* common/fifo_pkg.sv */
// shared types of the flag fifo
package fifo_pkg;

  // which offset register the serial loader is filling
  typedef enum logic {
    OFS_EMPTY_SIDE,
    OFS_FULL_SIDE
  } ofs_target_t;

  // read side sequencing around a rewind to the mark
  typedef enum logic {
    RD_RUN,
    RD_REWIND
  } rd_state_t;

endpackage : fifo_pkg

/* common/fifo_stream_if.sv */
// valid/ready stream between the top and its staging buffer
`timescale 1ns/100ps
`default_nettype none
interface fifo_stream_if #(
  parameter int WIDTH = 18
);
  logic             in_valid;   // filling side offers a word
  logic             in_ready;   // buffer has room
  logic [WIDTH-1:0] in_data;    // word offered
  logic             out_valid;  // buffer holds a word
  logic             out_ready;  // draining side takes it
  logic [WIDTH-1:0] out_data;   // oldest word

  modport buffer (
    input  in_valid,
    input  in_data,
    input  out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input  in_ready,
    input  out_valid,
    input  out_data
  );
endinterface : fifo_stream_if
`default_nettype wire

/* src/fifo_store.sv */
// small staging fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module fifo_store #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  fifo_stream_if.buffer      port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];  // storage, no reset needed
  logic [AW-1:0]    head_r;         // next slot to write
  logic [AW-1:0]    tail_r;         // next slot to read
  logic [AW:0]      count_r;        // words held
  logic             push;
  logic             pop;

  // honest flags straight from the count
  assign port.in_ready  = (count_r != (AW+1)'(DEPTH));
  assign port.out_valid = (count_r != '0);
  assign port.out_data  = mem_r[tail_r];
  assign push           = port.in_valid & port.in_ready;
  assign pop            = port.out_valid & port.out_ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[head_r] <= port.in_data;
    end
  end

  // pointers and count; wrap is explicit so depth need not be a power of two
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      head_r  <= '0;
      tail_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        head_r <= (head_r == AW'(DEPTH - 1)) ? '0 : head_r + 1'b1;
      end
      if (pop) begin
        tail_r <= (tail_r == AW'(DEPTH - 1)) ? '0 : tail_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : fifo_store
`default_nettype wire

/* verification/flag_fifo_props.sv */
// port assertions of the flag fifo top
`timescale 1ns/100ps
`default_nettype none
module flag_fifo_props #(
  parameter int DATA_W = 18  // word width
) (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic                  fall_through_mode,
  input wire logic                  flag_timing_select,
  input wire logic                  write_n,
  input wire logic [DATA_W-1:0]     write_data,
  input wire logic                  write_accept,
  input wire logic                  read_n,
  input wire logic                  read_select_n,
  input wire logic                  retransmit_n,
  input wire logic                  mark_n,
  input wire logic                  load_n,
  input wire logic                  serial_en_n,
  input wire logic                  serial_in,
  input wire logic [DATA_W-1:0]     read_data,
  input wire logic                  empty_flag_n,
  input wire logic                  input_ready_n,
  input wire logic                  almost_empty_n,
  input wire logic                  almost_full_n,
  input wire fifo_pkg::ofs_target_t load_target
);
  import fifo_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // helpers; sync flag mode only, the direct mode may lead the empty flag by a cycle
  wire std_m   = !fall_through_mode && flag_timing_select && mark_n;  // plain standard running
  wire rd_take = !read_n && !read_select_n && retransmit_n && empty_flag_n;  // standard read taken
  wire ft_idle = fall_through_mode && !empty_flag_n && (read_n || read_select_n) && retransmit_n;  // word held
  wire wr_take = !write_n && write_accept && mark_n;  // write taken, no mark held

  read_hold_a: assert property (std_m && !rd_take |=> $stable(read_data))
    else $error("read data changed without a taken read");
  ft_hold_a: assert property (ft_idle |=> $stable(read_data))
    else $error("fall-through word moved without both strobes");
  full_flags_a: assert property (std_m && !input_ready_n |-> empty_flag_n && !almost_full_n)
    else $error("full array shows empty or not almost full");
  empty_ae_a: assert property (std_m && !empty_flag_n |-> !almost_empty_n)
    else $error("empty array not almost empty");
  buffer_full_a: assert property ($fell(write_accept) && mark_n |-> input_ready_n == fall_through_mode)
    else $error("staging buffer refused while array not full");
  target_load_a: assert property ($changed(load_target) |-> $past(!load_n && !serial_en_n))
    else $error("offset target moved without a serial bit");
  std_release_a: assert property (std_m && !empty_flag_n && wr_take |-> ##[1:4] empty_flag_n)
    else $error("empty flag not released after a write");
  ft_ready_a: assert property (fall_through_mode && empty_flag_n && wr_take |-> ##[1:5] !empty_flag_n)
    else $error("output ready not given after first write");
  rewind_empty_a: assert property (!fall_through_mode && !mark_n && $fell(retransmit_n)
    |=> !empty_flag_n ##[1:3] empty_flag_n) else $error("rewind did not force then release empty");

  // main scenarios reached
  cover property (std_m && $rose(empty_flag_n));
  cover property (!write_accept);
  cover property (fall_through_mode && $fell(empty_flag_n));
endmodule : flag_fifo_props
`default_nettype wire

/* verification/stream_partner.sv */
// writer and reader logic standing in front of the flag fifo
`timescale 1ns/100ps
`default_nettype none
module stream_partner #(
  parameter int DATA_W = 18  // word width
) (
  input  wire logic              clk,
  input  wire logic              ft,            // fall-through strap in force
  input  wire logic              write_accept,
  input  wire logic              empty_flag_n,
  input  wire logic [DATA_W-1:0] read_data,
  output var  logic              write_n,
  output var  logic [DATA_W-1:0] write_data,
  output var  logic              read_n,
  output var  logic              read_select_n,
  output var  logic              retransmit_n
);
  int hangs = 0;  // bounded waits that ran out

  // idle levels from time zero; rewind input stays high outside rewinds
  initial begin
    write_n       = 1'h1;
    write_data    = '0;
    read_n        = 1'h1;
    read_select_n = 1'h1;
    retransmit_n  = 1'h1;
  end

  // offer one word and hold it until the edge that takes it
  task automatic push(input logic [DATA_W-1:0] w);
    int i;
    @(negedge clk);
    write_n    = 1'h0;
    write_data = w;
    for (i = 0; i < 60 && write_accept !== 1'h1; i++) @(negedge clk);
    if (i == 60) hangs++;
    @(negedge clk);
    write_n    = 1'h1;
    write_data = ~w;  // released bus shows the inverse, never the old word
  endtask : push

  // select first, strobe a cycle later, so a fall-through word is never lost
  task automatic pull(output logic [DATA_W-1:0] d);
    int i;
    @(negedge clk);
    read_select_n = 1'h0;
    @(negedge clk);
    for (i = 0; i < 60 && empty_flag_n !== !ft; i++) @(negedge clk);
    if (i == 60) hangs++;
    d      = read_data;  // fall-through shows the word before the strobe
    read_n = 1'h0;
    @(negedge clk);
    read_n        = 1'h1;
    read_select_n = 1'h1;
    if (!ft) d = read_data;  // standard delivers after the taking edge
  endtask : pull

  // one-cycle rewind request, high again before any read
  task automatic rewind();
    @(negedge clk);
    retransmit_n = 1'h0;
    @(negedge clk);
    retransmit_n = 1'h1;
  endtask : rewind
endmodule : stream_partner
`default_nettype wire

/* verification/flag_fifo_top_bench.sv */
// self-checking bench of the flag fifo top with its reader and writer model
`timescale 1ns/100ps
`default_nettype none
`include "fifo_map.svh"
module flag_fifo_top_bench;
  import fifo_pkg::*;
  localparam int AW = 4;  // 16-word array keeps fills short
  localparam int OB = `FIFO_OFS_BITS_MIN + AW - `FIFO_ADDR_W_MIN;  // offset length at this depth
  typedef struct {logic [17:0] w; logic ae;} row_t;  // word and almost-empty after it
  logic        clk, rstn, fall_through_mode, flag_timing_select, write_n, write_accept;
  logic        read_n, read_select_n, retransmit_n, mark_n, load_n, serial_en_n, serial_in;
  logic        empty_flag_n, input_ready_n, almost_empty_n, almost_full_n;
  logic [17:0] write_data, read_data, d;
  ofs_target_t load_target;
  int          num_errors = 0;
  int          n_compared = 0;
  row_t        rows [5] = '{'{18'h0A001, 1'h0}, '{18'h35002, 1'h0}, '{18'h3FFFF, 1'h0},
                            '{18'h00000, 1'h1}, '{18'h1C3C3, 1'h1}};

  flag_fifo_top #(.ADDR_W(AW)) dut (.clk, .rstn, .fall_through_mode, .flag_timing_select, .write_n,
    .write_data, .write_accept, .read_n, .read_select_n, .retransmit_n, .mark_n, .load_n, .serial_en_n,
    .serial_in, .read_data, .empty_flag_n, .input_ready_n, .almost_empty_n, .almost_full_n, .load_target);
  stream_partner pm (.clk, .ft(fall_through_mode), .write_accept, .empty_flag_n, .read_data, .write_n,
    .write_data, .read_n, .read_select_n, .retransmit_n);

  // 125 MHz clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // counts, verdict and end of run
  task automatic conclude();
    num_errors += pm.hangs;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // reset with a strap value, checking the reset levels
  task automatic do_reset(input logic mode);
    @(negedge clk);
    rstn              = 1'h0;
    fall_through_mode = mode;
    repeat (2) @(negedge clk);
    check({empty_flag_n, input_ready_n, almost_empty_n, almost_full_n, write_accept, load_target}, 6'h16, "flags");
    check(read_data, 18'h00000, "reset data");
    rstn = 1'h1;
    repeat (2) @(negedge clk);  // first edge captures the straps
  endtask : do_reset

  // shift one offset lsb first; the target must hold until the last bit
  task automatic shift(input logic [OB-1:0] v, input ofs_target_t tgt);
    for (int i = 0; i < OB; i++) begin
      @(negedge clk);
      if (i == OB - 1) check(load_target, tgt, "target held");
      load_n      = 1'h0;
      serial_en_n = 1'h0;
      serial_in   = v[i];
    end
    @(negedge clk);
    load_n      = 1'h1;
    serial_en_n = 1'h1;
    check(load_target, !tgt, "target flipped");
  endtask : shift

  // hang guard
  initial begin
    for (int c = 0; c < 20000 && pm.hangs == 0; c++) @(posedge clk);
    num_errors++;
    conclude();
  end

  // main sequence
  initial begin
    rstn               = 1'h0;
    fall_through_mode  = 1'h0;
    flag_timing_select = 1'h1;  // synchronous almost flags
    mark_n             = 1'h1;
    load_n             = 1'h1;
    serial_en_n        = 1'h1;
    serial_in          = 1'h0;
    do_reset(1'h0);
    shift(OB'(3), OFS_EMPTY_SIDE);  // almost-empty at three words or fewer
    shift(OB'(3), OFS_FULL_SIDE);   // almost-full at thirteen words or more
    $display("done offset load");
    foreach (rows[i]) begin
      pm.push(rows[i].w);
      @(negedge clk);
      if (i == 0) check(empty_flag_n, 1'h0, "empty one cycle");
      @(negedge clk);
      check(empty_flag_n, 1'h1, "empty released");
      check(almost_empty_n, rows[i].ae, "almost empty");
    end
    foreach (rows[i]) begin
      pm.pull(d);
      check(d, rows[i].w, "read word");
    end
    check(empty_flag_n, 1'h0, "empty after drain");
    $display("done standard rows");
    // fill array and staging buffer until refused, then drain all
    for (int i = 0; i < 24; i++) pm.push(18'(18'h00100 + i));
    check({input_ready_n, almost_full_n, write_accept}, 3'h0, "full");
    for (int i = 0; i < 24; i++) begin
      pm.pull(d);
      check(d, 18'h00100 + i, "fill order");
    end
    @(negedge clk);
    check({empty_flag_n, almost_full_n}, 2'h1, "drained");
    $display("done fill and drain");
    // mark the oldest word, read two, rewind and read it again
    for (int i = 0; i < 4; i++) pm.push(18'(18'h00200 + i));
    repeat (3) @(negedge clk);
    mark_n = 1'h0;
    pm.pull(d);
    pm.pull(d);
    pm.rewind();
    check(empty_flag_n, 1'h0, "rewind forces empty");
    pm.pull(d);
    check(d, 18'h00200, "replay from mark");
    mark_n = 1'h1;
    $display("done retransmit");
    // fall-through: first word falls through, later ones need both strobes
    do_reset(1'h1);
    check(input_ready_n, 1'h0, "room");
    pm.push(18'h2AAAA);
    repeat (2) @(negedge clk);
    check(empty_flag_n, 1'h1, "not ready yet");
    @(negedge clk);
    check(empty_flag_n, 1'h0, "output ready");
    check(read_data, 18'h2AAAA, "fell through");
    pm.push(18'h15555);
    pm.pull(d);
    check(d, 18'h2AAAA, "first word");
    pm.pull(d);
    check(d, 18'h15555, "second word");
    check(empty_flag_n, 1'h1, "nothing behind");
    $display("done fall-through");
    conclude();
  end
endmodule : flag_fifo_top_bench

bind flag_fifo_top flag_fifo_props #(.DATA_W(DATA_W)) props (.clk, .rstn, .fall_through_mode,
  .flag_timing_select, .write_n, .write_data, .write_accept, .read_n, .read_select_n, .retransmit_n,
  .mark_n, .load_n, .serial_en_n, .serial_in, .read_data, .empty_flag_n, .input_ready_n,
  .almost_empty_n, .almost_full_n, .load_target);
`default_nettype wire
